// [core/swrpc_map.svh]
`ifndef SWRPC_MAP_SVH
`define SWRPC_MAP_SVH

// command codes
`define SWRPC_CMD_RESET 8'hB4
`define SWRPC_CMD_BIT 8'h87

// read pointer positions
`define SWRPC_PTR_STATUS 2'h0
`define SWRPC_PTR_DATA 2'h1

// timebase
`define SWRPC_CLK_MHZ 100

// reset-low time: base plus step per code, in microseconds
`define SWRPC_RSTL_BASE_US 440
`define SWRPC_RSTL_STEP_US 20
// overdrive reset-low time is one tenth of standard
`define SWRPC_OD_DIV 10

// short sample time after release, in nanoseconds
`define SWRPC_SI_STD_NS 8000
`define SWRPC_SI_OD_NS 1000

// latest start of line activity after the acknowledge edge, in picoseconds
`define SWRPC_ACT_MAX_PS 262500
`define SWRPC_CLK_PERIOD_PS 10000

// reset values
`define SWRPC_RST_FLAG 1'b0
`define SWRPC_RST_OE_N 1'b1

`endif

// [core/swrpc_pkg.sv]
package swrpc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_ACK,
    ST_LOW,
    ST_RELEASE,
    ST_WAIT_PARAM
  } swrpc_state_e;

  typedef struct packed {
    swrpc_state_e st;
    logic [17:0] cnt;
    logic [17:0] rstl;
    logic [17:0] msp;
    logic [17:0] si;
    logic busy;
    logic presence_flag;
    logic short_flag;
    logic oe_n;
    logic pullup_on;
    logic ack;
    logic nack;
    logic bit_req;
    logic bit_val;
    logic [1:0] rptr;
  } swrpc_regs_s;

endpackage

// [core/swrpc_line_sync.sv]
`timescale 1ns/1ps
module swrpc_line_sync (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // idle line is pulled high
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change accepted only when second and third stage agree
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign o_level = lvl_q;

endmodule

// [core/swrpc_reset_cycle.sv]
`timescale 1ns/1ps
`include "swrpc_map.svh"

// Function
// - command B4h, no parameter, drives one bus reset then a presence window
// - sample line at short and presence times into the two status flags
// - code arriving while busy is not acknowledged and is discarded
// - whole command lasts twice reset-low time plus at most 262.5ns
// - line activity starts within 262.5ns of the acknowledge falling edge
// - accepted reset points the read pointer at the status register
// - busy high for twice reset-low; flags updated at their sample times
// - reset-low 440 to 740us in 20us steps, tenth at overdrive
module swrpc_reset_cycle #(
  parameter int CYC_PER_US = `SWRPC_CLK_MHZ
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_param_valid,
  input wire logic [7:0] i_param_byte,
  input wire logic i_ack_fall,
  input wire logic i_overdrive_speed_select,
  input wire logic i_active_pullup_enable,
  input wire logic [3:0] i_reset_low_code_std,
  input wire logic [3:0] i_reset_low_code_od,
  input wire logic [3:0] i_presence_code_std,
  input wire logic [3:0] i_presence_code_od,
  input wire logic i_line,
  output logic o_line_out,
  output logic o_line_oe_n,
  output logic o_active_pullup,
  output logic o_cmd_ack,
  output logic o_cmd_nack,
  output logic o_line_busy_flag,
  output logic o_presence_pulse_flag,
  output logic o_short_detect_flag,
  output logic [1:0] o_read_ptr,
  output logic o_single_bit_req,
  output logic o_single_bit_value
);

  swrpc_pkg::swrpc_regs_s r_q;
  swrpc_pkg::swrpc_regs_s r_d;
  logic line_lvl;
  logic line_lo_q;

  swrpc_line_sync u_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(i_line),
    .o_level(line_lvl)
  );

  // presence sample time in tenths of a microsecond
  function automatic int msp_tenths(input logic od, input logic [3:0] code);
    int v;
    v = 0;
    if (od) begin
      v = (code <= 4'h1) ? 55 : 50 + 5 * int'(code);
      if (v > 110) begin
        v = 110;
      end
    end else begin
      v = (code <= 4'h1) ? 580 : 560 + 20 * int'(code);
      if (v > 760) begin
        v = 760;
      end
    end
    return v;
  endfunction

  function automatic logic [17:0] rstl_cycles(input logic od, input logic [3:0] code);
    int us;
    int c;
    us = `SWRPC_RSTL_BASE_US + `SWRPC_RSTL_STEP_US * int'(code);
    c = od ? (us * CYC_PER_US) / `SWRPC_OD_DIV : us * CYC_PER_US;
    if (c < 1) begin
      c = 1;
    end
    return c[17:0];
  endfunction

  function automatic logic [17:0] msp_cycles(input logic od, input logic [3:0] code);
    int c;
    c = (msp_tenths(od, code) * CYC_PER_US) / 10;
    if (c < 1) begin
      c = 1;
    end
    return c[17:0];
  endfunction

  function automatic logic [17:0] si_cycles(input logic od);
    int ns;
    int c;
    ns = od ? `SWRPC_SI_OD_NS : `SWRPC_SI_STD_NS;
    c = (ns * CYC_PER_US) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[17:0];
  endfunction

  always_comb begin
    logic od;
    logic [3:0] rcode;
    logic [3:0] pcode;
    logic refuse;
    od = i_overdrive_speed_select;
    rcode = od ? i_reset_low_code_od : i_reset_low_code_std;
    pcode = od ? i_presence_code_od : i_presence_code_std;
    // busy is only ever high in the low and release states, so refusal is decided there
    refuse = i_cmd_valid &&
      (i_cmd_code == `SWRPC_CMD_RESET || i_cmd_code == `SWRPC_CMD_BIT);
    r_d = r_q;
    r_d.ack = 1'b0;
    r_d.nack = 1'b0;
    r_d.bit_req = 1'b0;
    r_d.pullup_on = 1'b0;
    case (r_q.st)
      swrpc_pkg::ST_IDLE: begin
        if (i_cmd_valid && i_cmd_code == `SWRPC_CMD_RESET) begin
          if (r_q.busy) begin
            r_d.nack = 1'b1;
          end else begin
            r_d.ack = 1'b1;
            r_d.rptr = `SWRPC_PTR_STATUS;
            r_d.st = swrpc_pkg::ST_WAIT_ACK;
          end
        end else if (i_cmd_valid && i_cmd_code == `SWRPC_CMD_BIT) begin
          if (r_q.busy) begin
            r_d.nack = 1'b1;
          end else begin
            r_d.ack = 1'b1;
            r_d.st = swrpc_pkg::ST_WAIT_PARAM;
          end
        end
      end
      swrpc_pkg::ST_WAIT_ACK: begin
        // settings are latched at the acknowledge edge, so a mid-cycle
        // change cannot stretch or cut the waveform
        if (i_ack_fall) begin
          r_d.rstl = rstl_cycles(od, rcode);
          r_d.msp = msp_cycles(od, pcode);
          r_d.si = si_cycles(od);
          r_d.cnt = 18'h00000;
          r_d.busy = 1'b1;
          r_d.oe_n = 1'b0;
          r_d.st = swrpc_pkg::ST_LOW;
        end
      end
      swrpc_pkg::ST_LOW: begin
        r_d.nack = refuse;
        r_d.cnt = r_q.cnt + 18'h00001;
        if (r_q.cnt == r_q.rstl - 18'h00001) begin
          r_d.cnt = 18'h00000;
          r_d.oe_n = 1'b1;
          r_d.st = swrpc_pkg::ST_RELEASE;
        end
      end
      swrpc_pkg::ST_RELEASE: begin
        r_d.nack = refuse;
        r_d.cnt = r_q.cnt + 18'h00001;
        // boost the rising edge only until the line is seen high or the short sample time is reached
        r_d.pullup_on = i_active_pullup_enable && line_lo_q && r_q.cnt < r_q.si;
        if (r_q.cnt == r_q.si) begin
          r_d.short_flag = line_lo_q;
        end
        if (r_q.cnt == r_q.msp) begin
          r_d.presence_flag = line_lo_q;
        end
        if (r_q.cnt == r_q.rstl - 18'h00001) begin
          r_d.busy = 1'b0;
          r_d.cnt = 18'h00000;
          r_d.st = swrpc_pkg::ST_IDLE;
        end
      end
      swrpc_pkg::ST_WAIT_PARAM: begin
        if (i_param_valid) begin
          r_d.bit_req = 1'b1;
          r_d.bit_val = i_param_byte[7];
          r_d.rptr = `SWRPC_PTR_STATUS;
          r_d.st = swrpc_pkg::ST_IDLE;
        end
      end
      default: begin
        r_d.st = swrpc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      r_q.st <= swrpc_pkg::ST_IDLE;
      r_q.cnt <= 18'h00000;
      r_q.rstl <= 18'h00001;
      r_q.msp <= 18'h00001;
      r_q.si <= 18'h00001;
      r_q.busy <= `SWRPC_RST_FLAG;
      r_q.presence_flag <= `SWRPC_RST_FLAG;
      r_q.short_flag <= `SWRPC_RST_FLAG;
      r_q.oe_n <= `SWRPC_RST_OE_N;
      r_q.pullup_on <= 1'b0;
      r_q.ack <= 1'b0;
      r_q.nack <= 1'b0;
      r_q.bit_req <= 1'b0;
      r_q.bit_val <= 1'b0;
      r_q.rptr <= `SWRPC_PTR_STATUS;
      line_lo_q <= 1'b0;
    end else begin
      r_q <= r_d;
      line_lo_q <= ~line_lvl;
    end
  end

  // the master only ever pulls low; the high level comes from the pullup
  assign o_line_out = 1'b0;
  assign o_line_oe_n = r_q.oe_n;
  assign o_active_pullup = r_q.pullup_on;
  assign o_cmd_ack = r_q.ack;
  assign o_cmd_nack = r_q.nack;
  assign o_line_busy_flag = r_q.busy;
  assign o_presence_pulse_flag = r_q.presence_flag;
  assign o_short_detect_flag = r_q.short_flag;
  assign o_read_ptr = r_q.rptr;
  assign o_single_bit_req = r_q.bit_req;
  assign o_single_bit_value = r_q.bit_val;

endmodule

// [testbench/swrpc_monitor.sv]
`timescale 1ns/1ps
`include "swrpc_map.svh"
module swrpc_monitor #(
  parameter int CYC_PER_US = `SWRPC_CLK_MHZ
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_param_valid,
  input wire logic [7:0] i_param_byte,
  input wire logic i_ack_fall,
  input wire logic o_line_out,
  input wire logic o_line_oe_n,
  input wire logic o_cmd_ack,
  input wire logic o_cmd_nack,
  input wire logic o_line_busy_flag,
  input wire logic o_presence_pulse_flag,
  input wire logic o_short_detect_flag,
  input wire logic [1:0] o_read_ptr,
  input wire logic o_single_bit_req,
  input wire logic o_single_bit_value
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  int bc;
  int lc;
  // counters clear while idle so every cycle is judged on its own
  always_ff @(posedge i_mclk) begin
    bc <= (i_reset || !o_line_busy_flag) ? 0 : bc + 1;
    lc <= (i_reset || !o_line_busy_flag) ? 0 : lc + int'(!o_line_oe_n);
  end
  busy_nack_a: assert property (i_cmd_valid && o_line_busy_flag &&
    (i_cmd_code == `SWRPC_CMD_RESET || i_cmd_code == `SWRPC_CMD_BIT) |=>
    o_cmd_nack && !o_cmd_ack)
    else $error("busy code not refused");
  busy_start_a: assert property ($rose(o_line_busy_flag) |-> !o_line_oe_n && $past(i_ack_fall))
    else $error("line start late");
  busy_len_a: assert property ($fell(o_line_busy_flag) |-> bc == 2 * lc && lc > 0)
    else $error("busy not twice low time");
  low_in_busy_a: assert property (!o_line_oe_n |-> o_line_busy_flag && !o_line_out)
    else $error("line pulled outside cycle");
  flag_hold_a: assert property (!o_line_busy_flag |->
    $stable(o_presence_pulse_flag) && $stable(o_short_detect_flag))
    else $error("flag moved while idle");
  ptr_status_a: assert property (o_cmd_ack && $past(i_cmd_code) == `SWRPC_CMD_RESET |->
    o_read_ptr == `SWRPC_PTR_STATUS)
    else $error("pointer not at status");
  bit_req_a: assert property (o_single_bit_req |->
    $past(i_param_valid) && o_single_bit_value == $past(i_param_byte[7]))
    else $error("bit request wrong");
  ack_pulse_a: assert property (o_cmd_ack |-> $past(i_cmd_valid) ##1 !o_cmd_ack)
    else $error("ack pulse wrong");
  cover property ($fell(o_line_busy_flag));
  cover property (o_cmd_nack);
  cover property (o_single_bit_req);
endmodule
bind swrpc_reset_cycle swrpc_monitor #(.CYC_PER_US(CYC_PER_US)) u_mon (.*);

// [testbench/swrpc_slave.sv]
`timescale 1ns/1ps
module swrpc_slave (
  input wire logic i_mclk,
  input wire logic i_oe_n,
  input wire logic [1:0] i_mode,
  output logic o_line
);
  int t = 999;
  // slaves answer only after the master releases, as real ones do
  always @(posedge i_mclk) t <= !i_oe_n ? 0 : t + 1;
  // counts are cycles at ten per microsecond: presence 20 to 120us, short 100us
  assign o_line = !i_oe_n ? 1'b0 : i_mode == 2'h1 ? !(t >= 200 && t < 1200) :
    i_mode == 2'h2 ? !(t < 1000) : 1'b1;
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "swrpc_map.svh"
module testbench;
  logic i_mclk = 0, i_reset = 1, cv = 0, pv = 0, af = 0, od = 0, pu_en = 0;
  logic [7:0] code = 8'h00, pb = 8'h00;
  logic [3:0] rs = 4'h0, ro = 4'h0;
  logic [1:0] mode = 2'h0, ptr;
  logic line, oe_n, ack, nack, busy, pres, shrt, breq, bval, pu_out;
  int fail_count = 0, checks_done = 0;
  always #5 i_mclk = ~i_mclk;
  swrpc_slave u_slave (.i_mclk(i_mclk), .i_oe_n(oe_n), .i_mode(mode), .o_line(line));
  // ten cycles per microsecond keeps the synchroniser lag below the shortest sample time
  swrpc_reset_cycle #(.CYC_PER_US(10)) DUT (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_cmd_valid(cv), .i_cmd_code(code), .i_param_valid(pv), .i_param_byte(pb),
    .i_ack_fall(af), .i_overdrive_speed_select(od), .i_active_pullup_enable(pu_en),
    .i_reset_low_code_std(rs), .i_reset_low_code_od(ro), .i_presence_code_std(4'h0),
    .i_presence_code_od(4'h0), .i_line(line), .o_line_out(), .o_line_oe_n(oe_n),
    .o_active_pullup(pu_out), .o_cmd_ack(ack), .o_cmd_nack(nack),
    .o_line_busy_flag(busy), .o_presence_pulse_flag(pres), .o_short_detect_flag(shrt),
    .o_read_ptr(ptr), .o_single_bit_req(breq), .o_single_bit_value(bval));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] c);
    cv = 1;
    code = c;
    @(negedge i_mclk) cv = 0;
  endtask
  task automatic run_reset(input int r, input logic e_short, input logic e_pres);
    int n;
    int lo;
    int hi;
    n = 0;
    lo = 0;
    hi = 0;
    send(`SWRPC_CMD_RESET);
    chk(ack, 1);
    chk(ptr, 2'h0);
    af = 1;
    @(negedge i_mclk) af = 0;
    chk(oe_n, 0);
    // host polls busy and re-sends the reset code mid-cycle, expecting it refused
    while (busy === 1'b1 && n < 20000) begin
      if (n == 5) begin
        cv = 1;
        code = `SWRPC_CMD_RESET;
      end
      if (n == 6) begin
        cv = 0;
        chk({ack, nack}, 2'b01);
      end
      n++;
      lo += int'(oe_n === 1'b0);
      hi += int'(pu_out === 1'b1);
      @(negedge i_mclk);
    end
    chk(n, 2 * r);
    chk(lo, r);
    chk({shrt, pres}, {e_short, e_pres});
    chk(hi > 0, pu_en);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (6) @(negedge i_mclk);
    i_reset = 0;
    @(negedge i_mclk);
    mode = 2'h1;
    run_reset(4400, 0, 1);
    send(`SWRPC_CMD_BIT);
    chk(ack, 1);
    pb = 8'h80;
    pv = 1;
    @(negedge i_mclk) pv = 0;
    chk({breq, bval}, 2'b11);
    mode = 2'h2;
    pu_en = 1;
    rs = 4'hF;
    run_reset(7400, 1, 1);
    mode = 2'h0;
    od = 1;
    pu_en = 0;
    run_reset(440, 0, 0);
    send(8'h55);
    chk({ack, nack}, 2'b00);
    stop_test;
  end
endmodule
